// ===== rtl/gom_pkg.sv
// Constants and carrier types for the pin 2 output source multiplexer
package gom_pkg;

  // ****************************************************
  // Register map (byte addresses on the Avalon bus)
  // ****************************************************
  localparam int ADDR_W = 9;
  localparam logic [6:0] CTRL_INDEX = 7'h12;
  localparam logic [6:0] STATUS_INDEX = 7'h40;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] STATUS_ADDR = {STATUS_INDEX, 2'b00};

  // ****************************************************
  // Control register fields and reset value
  // ****************************************************
  localparam int DRIVE_EN_BIT = 0;
  localparam int LOCAL_LEVEL_BIT = 1;
  localparam int SOURCE_LSB = 2;
  localparam int SELECT_LSB = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register bit positions
  localparam int STAT_PIN_BIT = 0;
  localparam int STAT_MUX_BIT = 1;

  // ****************************************************
  // Source group codes
  // ****************************************************
  localparam logic [2:0] SRC_DEVICE = 3'h4;
  localparam logic [2:0] SRC_RSVD_A = 3'h5;
  localparam logic [2:0] SRC_TX0 = 3'h6;
  localparam logic [2:0] SRC_RSVD_B = 3'h7;

  // Receive port signal selects
  localparam logic [2:0] RX_SEL_LOCK = 3'h4;
  localparam logic [2:0] RX_SEL_PASS = 3'h5;
  localparam logic [2:0] RX_SEL_FV = 3'h6;
  localparam logic [2:0] RX_SEL_LV = 3'h7;

  // Device status signal selects
  localparam logic [2:0] DEV_SEL_LOCAL = 3'h0;
  localparam logic [2:0] DEV_SEL_LOCK_OR = 3'h1;
  localparam logic [2:0] DEV_SEL_LOCK_AND = 3'h2;
  localparam logic [2:0] DEV_SEL_PASS_AND = 3'h3;
  localparam logic [2:0] DEV_SEL_FSYNC = 3'h4;

  // Transmit port signal selects
  localparam logic [2:0] TX_SEL_PASS_AND = 3'h0;
  localparam logic [2:0] TX_SEL_PASS_OR = 3'h1;
  localparam logic [2:0] TX_SEL_FV = 3'h2;
  localparam logic [2:0] TX_SEL_LV = 3'h3;
  localparam logic [2:0] TX_SEL_SYNC = 3'h4;
  localparam logic [2:0] TX_SEL_IRQ = 3'h5;

  // ****************************************************
  // Avalon response codes
  // ****************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************
  // Carrier types
  // ****************************************************
  typedef struct packed {
    logic [2:0] pin2_signal_select;
    logic [2:0] pin2_source_group;
    logic pin2_local_level;
    logic pin2_drive_enable;
  } gom_ctrl_type;

  typedef struct packed {
    logic enabled;
    logic [3:0] remote_gpio;
    logic lock;
    logic pass;
    logic frame_valid;
    logic line_valid;
  } gom_rx_type;

  typedef struct packed {
    logic [3:0] port_mask;
    logic frame_valid;
    logic line_valid;
    logic synchronized;
    logic interrupt;
  } gom_tx_type;

  typedef struct packed {
    gom_ctrl_type ctrl;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic pin_out;
    logic pin_oe_n;
    logic pin_s1;
    logic pin_s2;
  } gom_state_type;

endpackage

// ===== rtl/gom_pin2_mux.sv
// Pin 2 output source multiplexer with its Avalon-MM control register
//
// Decided for this implementation: the Avalon-MM slave port.
module gom_pin2_mux (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [gom_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic [1:0] response,
  output logic waitrequest,
  input wire gom_pkg::gom_rx_type [3:0] rx_status,
  input wire gom_pkg::gom_tx_type tx_status,
  input wire logic frame_sync_pulse,
  input wire logic pin2_in,
  output logic pin2_out,
  output logic pin2_oe_n
);
  import gom_pkg::*;

  gom_state_type q;
  gom_state_type d;
  gom_rx_type rx_pick;
  logic [3:0] en_vec;
  logic [3:0] lock_vec;
  logic [3:0] pass_vec;
  logic any_enabled;
  logic lock_or;
  logic lock_and;
  logic pass_and;
  logic fwd_pass_and;
  logic fwd_pass_or;
  logic mux_value;
  logic req;
  logic accept;

  // ****************************************************
  // Aggregates over receive ports
  // ****************************************************
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      en_vec[i] = rx_status[i].enabled;
      lock_vec[i] = rx_status[i].lock;
      pass_vec[i] = rx_status[i].pass;
    end
  end

  // Empty set of ports gives low, never a false pass
  assign any_enabled = |en_vec;
  assign lock_or = |(lock_vec & en_vec);
  assign lock_and = any_enabled & (&(lock_vec | ~en_vec));
  assign pass_and = any_enabled & (&(pass_vec | ~en_vec));
  assign fwd_pass_and = (|tx_status.port_mask) &
    (&(pass_vec | ~tx_status.port_mask));
  assign fwd_pass_or = |(pass_vec & tx_status.port_mask);

  // ****************************************************
  // Source and signal selection
  // ****************************************************
  assign rx_pick = rx_status[q.ctrl.pin2_source_group[1:0]];

  always_comb begin
    mux_value = 1'b0;
    if (!q.ctrl.pin2_source_group[2]) begin
      case (q.ctrl.pin2_signal_select)
        RX_SEL_LOCK: mux_value = rx_pick.lock;
        RX_SEL_PASS: mux_value = rx_pick.pass;
        RX_SEL_FV: mux_value = rx_pick.frame_valid;
        RX_SEL_LV: mux_value = rx_pick.line_valid;
        default: begin
          mux_value = rx_pick.remote_gpio[q.ctrl.pin2_signal_select[1:0]];
        end
      endcase
    end else if (q.ctrl.pin2_source_group == SRC_DEVICE) begin
      case (q.ctrl.pin2_signal_select)
        DEV_SEL_LOCAL: mux_value = q.ctrl.pin2_local_level;
        DEV_SEL_LOCK_OR: mux_value = lock_or;
        DEV_SEL_LOCK_AND: mux_value = lock_and;
        DEV_SEL_PASS_AND: mux_value = pass_and;
        DEV_SEL_FSYNC: mux_value = frame_sync_pulse;
        default: mux_value = 1'b0;
      endcase
    end else if (q.ctrl.pin2_source_group == SRC_TX0) begin
      case (q.ctrl.pin2_signal_select)
        TX_SEL_PASS_AND: mux_value = fwd_pass_and;
        TX_SEL_PASS_OR: mux_value = fwd_pass_or;
        TX_SEL_FV: mux_value = tx_status.frame_valid;
        TX_SEL_LV: mux_value = tx_status.line_valid;
        TX_SEL_SYNC: mux_value = tx_status.synchronized;
        TX_SEL_IRQ: mux_value = tx_status.interrupt;
        default: mux_value = 1'b0;
      endcase
    end else begin
      // Reserved source groups drive low
      mux_value = 1'b0;
    end
  end

  // ****************************************************
  // Bus handshake: one wait cycle, then accept
  // ****************************************************
  assign req = read | write;
  assign accept = req & q.ack;
  assign waitrequest = req & ~q.ack;

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    d = q;
    d.ack = req & ~q.ack;
    // Pin input synchroniser
    d.pin_s1 = pin2_in;
    d.pin_s2 = q.pin_s1;
    if (req && !q.ack) begin
      d.rdata = 32'h0000_0000;
      d.resp = RESP_OKAY;
      if (address == CTRL_ADDR) begin
        d.rdata[7:0] = q.ctrl;
      end else if (address == STATUS_ADDR) begin
        d.rdata[STAT_PIN_BIT] = q.pin_s2;
        d.rdata[STAT_MUX_BIT] = mux_value;
      end else begin
        d.resp = RESP_SLVERR;
      end
    end
    if (accept && write && address == CTRL_ADDR && byteenable[0]) begin
      d.ctrl = writedata[7:0];
    end
    d.pin_oe_n = ~q.ctrl.pin2_drive_enable;
    d.pin_out = q.ctrl.pin2_drive_enable & mux_value;
    if (!reset_n) begin
      d.ctrl = CTRL_RESET;
      d.ack = 1'b0;
      d.rdata = 32'h0000_0000;
      d.resp = RESP_OKAY;
      d.pin_out = 1'b0;
      d.pin_oe_n = 1'b1;
      d.pin_s1 = 1'b0;
      d.pin_s2 = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign readdata = q.rdata;
  assign response = q.resp;
  assign pin2_out = q.pin_out;
  assign pin2_oe_n = q.pin_oe_n;

  // ****************************************************
  // Checks
  // ****************************************************
  property p_bus_answer;
    @(posedge clk) disable iff (!reset_n)
    (read || write) |-> ##[0:1] !waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("Bus request not answered within one wait cycle");

  property p_ctrl_write;
    @(posedge clk) disable iff (!reset_n)
    (write && !waitrequest && address == CTRL_ADDR && byteenable[0])
      |=> (q.ctrl == $past(writedata[7:0]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("Control write did not land");

  property p_enable_drive;
    @(posedge clk) disable iff (!reset_n)
    q.ctrl.pin2_drive_enable ##1 q.ctrl.pin2_drive_enable |-> !pin2_oe_n;
  endproperty
  a_enable_drive: assert property (p_enable_drive)
    else $error("Pin not driven while enabled");

  property p_disable_quiet;
    @(posedge clk) disable iff (!reset_n)
    !q.ctrl.pin2_drive_enable |=> (pin2_oe_n && !pin2_out);
  endproperty
  a_disable_quiet: assert property (p_disable_quiet)
    else $error("Pin driven while disabled");

  property p_local_level;
    @(posedge clk) disable iff (!reset_n)
    (q.ctrl.pin2_drive_enable && q.ctrl.pin2_source_group == SRC_DEVICE &&
      q.ctrl.pin2_signal_select == DEV_SEL_LOCAL)
      |=> (pin2_out == $past(q.ctrl.pin2_local_level));
  endproperty
  a_local_level: assert property (p_local_level)
    else $error("Local level not on pin");

  property p_reserved_src;
    @(posedge clk) disable iff (!reset_n)
    (q.ctrl.pin2_source_group == SRC_RSVD_A ||
      q.ctrl.pin2_source_group == SRC_RSVD_B) |=> !pin2_out;
  endproperty
  a_reserved_src: assert property (p_reserved_src)
    else $error("Reserved source drove high");

  property p_rx_gpio;
    @(posedge clk) disable iff (!reset_n)
    (q.ctrl.pin2_drive_enable && q.ctrl.pin2_source_group == 3'h1 &&
      q.ctrl.pin2_signal_select == 3'h3)
      |=> (pin2_out == $past(rx_status[1].remote_gpio[3]));
  endproperty
  a_rx_gpio: assert property (p_rx_gpio)
    else $error("Remote input 3 of port 1 not on pin");

  property p_rx_lock;
    @(posedge clk) disable iff (!reset_n)
    (q.ctrl.pin2_drive_enable && q.ctrl.pin2_source_group == 3'h2 &&
      q.ctrl.pin2_signal_select == RX_SEL_LOCK)
      |=> (pin2_out == $past(rx_status[2].lock));
  endproperty
  a_rx_lock: assert property (p_rx_lock)
    else $error("Lock of port 2 not on pin");

  property p_rx_line;
    @(posedge clk) disable iff (!reset_n)
    (q.ctrl.pin2_drive_enable && q.ctrl.pin2_source_group == 3'h3 &&
      q.ctrl.pin2_signal_select == RX_SEL_LV)
      |=> (pin2_out == $past(rx_status[3].line_valid));
  endproperty
  a_rx_line: assert property (p_rx_line)
    else $error("Line valid of port 3 not on pin");

  property p_dev_lock_or;
    @(posedge clk) disable iff (!reset_n)
    (q.ctrl.pin2_drive_enable && q.ctrl.pin2_source_group == SRC_DEVICE &&
      q.ctrl.pin2_signal_select == DEV_SEL_LOCK_OR)
      |=> (pin2_out == $past(|(lock_vec & en_vec)));
  endproperty
  a_dev_lock_or: assert property (p_dev_lock_or)
    else $error("Lock OR not on pin");

  property p_dev_fsync;
    @(posedge clk) disable iff (!reset_n)
    (q.ctrl.pin2_drive_enable && q.ctrl.pin2_source_group == SRC_DEVICE &&
      q.ctrl.pin2_signal_select == DEV_SEL_FSYNC)
      |=> (pin2_out == $past(frame_sync_pulse));
  endproperty
  a_dev_fsync: assert property (p_dev_fsync)
    else $error("Frame sync not on pin");

  property p_tx_frame;
    @(posedge clk) disable iff (!reset_n)
    (q.ctrl.pin2_drive_enable && q.ctrl.pin2_source_group == SRC_TX0 &&
      q.ctrl.pin2_signal_select == TX_SEL_FV)
      |=> (pin2_out == $past(tx_status.frame_valid));
  endproperty
  a_tx_frame: assert property (p_tx_frame)
    else $error("Transmit frame valid not on pin");

  property p_tx_irq;
    @(posedge clk) disable iff (!reset_n)
    (q.ctrl.pin2_drive_enable && q.ctrl.pin2_source_group == SRC_TX0 &&
      q.ctrl.pin2_signal_select == TX_SEL_IRQ)
      |=> (pin2_out == $past(tx_status.interrupt));
  endproperty
  a_tx_irq: assert property (p_tx_irq)
    else $error("Transmit interrupt not on pin");

  property p_rx_pass;
    @(posedge clk) disable iff (!reset_n)
    (q.ctrl.pin2_drive_enable && q.ctrl.pin2_source_group == 3'h0 &&
      q.ctrl.pin2_signal_select == RX_SEL_PASS)
      |=> (pin2_out == $past(rx_status[0].pass));
  endproperty
  a_rx_pass: assert property (p_rx_pass)
    else $error("Pass of port 0 not on pin");

  property p_dev_lock_and;
    @(posedge clk) disable iff (!reset_n)
    (q.ctrl.pin2_drive_enable && q.ctrl.pin2_source_group == SRC_DEVICE &&
      q.ctrl.pin2_signal_select == DEV_SEL_LOCK_AND)
      |=> (pin2_out == $past((en_vec != 4'h0) &&
        ((lock_vec & en_vec) == en_vec)));
  endproperty
  a_dev_lock_and: assert property (p_dev_lock_and)
    else $error("Lock AND not on pin");

  property p_dev_rsvd_sel;
    @(posedge clk) disable iff (!reset_n)
    (q.ctrl.pin2_source_group == SRC_DEVICE &&
      q.ctrl.pin2_signal_select > DEV_SEL_FSYNC) |=> !pin2_out;
  endproperty
  a_dev_rsvd_sel: assert property (p_dev_rsvd_sel)
    else $error("Reserved status select drove high");

  property p_tx_sync;
    @(posedge clk) disable iff (!reset_n)
    (q.ctrl.pin2_drive_enable && q.ctrl.pin2_source_group == SRC_TX0 &&
      q.ctrl.pin2_signal_select == TX_SEL_SYNC)
      |=> (pin2_out == $past(tx_status.synchronized));
  endproperty
  a_tx_sync: assert property (p_tx_sync)
    else $error("Transmit synchronized not on pin");

endmodule

// ===== test/gom_board_model.sv
// Board logic that watches pin 2 through a pull-up
module gom_board_model (
  input wire logic clk,
  input wire logic pin2_out,
  input wire logic pin2_oe_n,
  output logic pin_level,
  output logic sampled_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released pin floats high
  assign pin_level = pin2_oe_n ? 1'b1 : pin2_out;
  always_ff @(posedge clk) begin
    sampled_q <= pin_level;
  end
endmodule

// ===== test/gom_pin2_mux_tb.sv
// Self-checking bench for the pin 2 output source multiplexer
module gom_pin2_mux_tb;
  import gom_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic [1:0] response;
  logic waitrequest;
  gom_rx_type [3:0] rx_status = '0;
  gom_tx_type tx_status = '0;
  logic frame_sync_pulse = 1'b0;
  logic pin2_out;
  logic pin2_oe_n;
  logic pin_level;
  logic pin_seen;
  int num_errors = 0;
  int num_checks = 0;

  always #25 clk = ~clk;

  gom_pin2_mux dut (.clk(clk), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .response(response),
    .waitrequest(waitrequest), .rx_status(rx_status),
    .tx_status(tx_status), .frame_sync_pulse(frame_sync_pulse),
    .pin2_in(pin_level), .pin2_out(pin2_out), .pin2_oe_n(pin2_oe_n));

  gom_board_model board (.clk(clk), .pin2_out(pin2_out),
    .pin2_oe_n(pin2_oe_n), .pin_level(pin_level), .sampled_q(pin_seen));

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q, output logic [1:0] r);
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    r = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // Pin value worked out from the control byte and the inputs
  function automatic logic [1:0] expect_pin(input logic [7:0] c);
    logic v;
    logic [3:0] en, lk, ps, pm;
    gom_rx_type p;
    for (int i = 0; i < 4; i++) begin
      en[i] = rx_status[i].enabled;
      lk[i] = rx_status[i].lock;
      ps[i] = rx_status[i].pass;
    end
    pm = tx_status.port_mask;
    p = rx_status[c[3:2]];
    v = 1'b0;
    case (c[4:2])
      3'h0, 3'h1, 3'h2, 3'h3: begin
        case (c[7:5])
          3'h4: v = p.lock;
          3'h5: v = p.pass;
          3'h6: v = p.frame_valid;
          3'h7: v = p.line_valid;
          default: v = p.remote_gpio[c[6:5]];
        endcase
      end
      3'h4: begin
        case (c[7:5])
          3'h0: v = c[1];
          3'h1: v = |(lk & en);
          3'h2: v = (en != 4'h0) && ((lk & en) == en);
          3'h3: v = (en != 4'h0) && ((ps & en) == en);
          3'h4: v = frame_sync_pulse;
          default: v = 1'b0;
        endcase
      end
      3'h6: begin
        case (c[7:5])
          3'h0: v = (pm != 4'h0) && ((ps & pm) == pm);
          3'h1: v = |(ps & pm);
          3'h2: v = tx_status.frame_valid;
          3'h3: v = tx_status.line_valid;
          3'h4: v = tx_status.synchronized;
          3'h5: v = tx_status.interrupt;
          default: v = 1'b0;
        endcase
      end
      default: v = 1'b0;
    endcase
    return c[0] ? {1'b0, v} : 2'b10;
  endfunction

  task automatic check_ctrl(input logic [7:0] c);
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b1, CTRL_ADDR, {24'h0, c}, 4'h1, q, r);
    bus(1'b0, CTRL_ADDR, 32'h0, 4'h1, q, r);
    check("control", q, {24'h0, c});
    #1;
    check("pin", {30'h0, pin2_oe_n, pin2_out}, {30'h0, expect_pin(c)});
  endtask

  // All select, level and enable codes of one source, three input sets
  task automatic sweep(input logic [2:0] src);
    for (int pat = 0; pat < 3; pat++) begin
      @(posedge clk);
      case (pat)
        0: begin
          rx_status <= 36'hfffffffff;
          tx_status <= 8'hff;
        end
        1: begin
          rx_status <= 36'h5a3c96e1b;
          tx_status <= 8'h3a;
        end
        default: begin
          // Ports 0 and 1 enabled, ports 0 and 2 locked
          rx_status <= {9'h0c3, 9'h039, 9'h196, 9'h16d};
          tx_status <= 8'h35;
        end
      endcase
      for (int k = 0; k < 32; k++) begin
        check_ctrl({k[4:2], src, k[1:0]});
      end
    end
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic test_reset();
    logic [31:0] q;
    logic [1:0] r;
    check("oe_n", {31'h0, pin2_oe_n}, 32'h1);
    bus(1'b0, CTRL_ADDR, 32'h0, 4'h1, q, r);
    check("ctrl reset", q, 32'h0);
    $display("test_reset done");
  endtask

  task automatic test_bus();
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b0, 9'h1fc, 32'h0, 4'h1, q, r);
    check("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    check("unmapped data", q, 32'h0);
    bus(1'b1, CTRL_ADDR, 32'hff, 4'h0, q, r);
    bus(1'b0, CTRL_ADDR, 32'h0, 4'h1, q, r);
    check("masked write", q, 32'h0);
    $display("test_bus done");
  endtask

  task automatic test_rx();
    for (int s = 0; s < 4; s++) begin
      sweep(s[2:0]);
    end
    $display("test_rx done");
  endtask

  task automatic test_dev();
    sweep(SRC_DEVICE);
    $display("test_dev done");
  endtask

  task automatic test_tx();
    sweep(SRC_TX0);
    $display("test_tx done");
  endtask

  task automatic test_reserved();
    sweep(SRC_RSVD_A);
    sweep(SRC_RSVD_B);
    $display("test_reserved done");
  endtask

  task automatic test_fsync();
    check_ctrl({DEV_SEL_FSYNC, SRC_DEVICE, 2'b01});
    @(posedge clk);
    frame_sync_pulse <= 1'b1;
    @(posedge clk);
    frame_sync_pulse <= 1'b0;
    #1;
    check("fsync high", {31'h0, pin2_out}, 32'h1);
    @(posedge clk);
    #1;
    check("fsync low", {31'h0, pin2_out}, 32'h0);
    $display("test_fsync done");
  endtask

  // Status shows the pulled-up pin apart from the selected value
  task automatic test_status();
    logic [31:0] q;
    logic [1:0] r;
    check_ctrl({DEV_SEL_LOCAL, SRC_DEVICE, 2'b11});
    bus(1'b0, STATUS_ADDR, 32'h0, 4'h1, q, r);
    check("status driven", q, 32'h3);
    check_ctrl({DEV_SEL_LOCAL, SRC_DEVICE, 2'b01});
    bus(1'b0, STATUS_ADDR, 32'h0, 4'h1, q, r);
    check("status low", q, 32'h0);
    check("board low", {31'h0, pin_seen}, 32'h0);
    check_ctrl({DEV_SEL_LOCAL, SRC_DEVICE, 2'b00});
    bus(1'b0, STATUS_ADDR, 32'h0, 4'h1, q, r);
    check("status released", q, 32'h1);
    check("board released", {31'h0, pin_seen}, 32'h1);
    $display("test_status done");
  endtask

  // Reset in mid-run drops the pin and clears the control byte
  task automatic test_midreset();
    logic [31:0] q;
    logic [1:0] r;
    check_ctrl({DEV_SEL_LOCAL, SRC_DEVICE, 2'b11});
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    check("reset pin", {30'h0, pin2_oe_n, pin2_out}, 32'h2);
    bus(1'b0, CTRL_ADDR, 32'h0, 4'h1, q, r);
    check("reset ctrl", q, {24'h0, CTRL_RESET});
    $display("test_midreset done");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    test_reset();
    test_bus();
    test_rx();
    test_dev();
    test_tx();
    test_reserved();
    test_fsync();
    test_status();
    test_midreset();
    complete_run();
  end

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule
